/* hdl/fsp_consts.vh */
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH

// ----------------------------------------
// nonvolatile addresses
// ----------------------------------------
`define FSP_SEC_NV_ADDR    23'h7FFF0F
`define FSP_PROT_NV_ADDR   23'h7FFF0D
`define FSP_KEY_LO_ADDR    23'h7FFF00
`define FSP_KEY_HI_ADDR    23'h7FFF07
`define FSP_DF_BASE        23'h100000
`define FSP_DF_PAGE_LSB    8

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FSP_OFS_SEC        8'h00
`define FSP_OFS_PROT       8'h04
`define FSP_OFS_FLASH_STATUS_REG      8'h08
`define FSP_OFS_IRQ_STAT   8'h0C
`define FSP_OFS_IRQ_MASK   8'h10

// ----------------------------------------
// field positions and patterns
// ----------------------------------------
`define FSP_KEYEN_HI       7
`define FSP_KEYEN_LO       6
`define FSP_LOCK_HI        1
`define FSP_LOCK_LO        0
`define FSP_PAT_ON         2'h2
`define FSP_OPEN_BIT       7
`define FSP_SIZE_HI        4
`define FSP_COMMAND_COMPLETE_FLAG_BIT       7
`define FSP_VIOL_BIT       4
`define FSP_IRQ_CC_BIT     0
`define FSP_IRQ_VIOL_BIT   1

// ----------------------------------------
// reset and fault values
// ----------------------------------------
`define FSP_SEC_FAULT      8'hFF
`define FSP_PROT_FAULT     8'h1F
`define FSP_SEC_RST        8'hFF
`define FSP_PROT_RST       8'h1F

// ----------------------------------------
// command codes
// ----------------------------------------
`define FSP_OP_PROGRAM     2'h0
`define FSP_OP_SECT_ERASE  2'h1
`define FSP_OP_BLK_ERASE   2'h2
`define FSP_OP_VERIFY_KEY  2'h3

`endif

/* hdl/fsp_loader.v */
`include "fsp_consts.vh"
`default_nettype none
module fsp_loader (
    // clock and reset
    input  wire        clock_i,
    input  wire        sys_rst_i,
    // nonvolatile read port
    output reg         rd_req_o,
    output reg  [22:0] rd_addr_o,
    input  wire        rd_valid_i,
    input  wire [7:0]  rd_data_i,
    input  wire        rd_dbl_fault_i,
    // loaded values
    output reg  [7:0]  sec_byte_o,
    output reg  [7:0]  prot_byte_o,
    output reg         done_o
);

localparam ST_SEC  = 2'h0;
localparam ST_PROT = 2'h1;
localparam ST_DONE = 2'h2;

reg [1:0] state;

// ----------------------------------------
// reset-sequence load, runs once per reset
// ----------------------------------------
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        state       <= ST_SEC;
        rd_req_o    <= 1'b0;
        rd_addr_o   <= `FSP_SEC_NV_ADDR;
        sec_byte_o  <= `FSP_SEC_RST;
        prot_byte_o <= `FSP_PROT_RST;
        done_o      <= 1'b0;
    end else begin
        case (state)
            ST_SEC: begin
                rd_req_o  <= ~rd_valid_i;
                rd_addr_o <= `FSP_SEC_NV_ADDR;
                if (rd_valid_i & rd_req_o) begin
                    sec_byte_o <= rd_dbl_fault_i ? `FSP_SEC_FAULT
                                                 : rd_data_i;
                    rd_addr_o  <= `FSP_PROT_NV_ADDR;
                    rd_req_o   <= 1'b0;
                    state      <= ST_PROT;
                end
            end
            ST_PROT: begin
                rd_req_o  <= ~rd_valid_i;
                rd_addr_o <= `FSP_PROT_NV_ADDR;
                if (rd_valid_i & rd_req_o) begin
                    prot_byte_o <= rd_dbl_fault_i ? `FSP_PROT_FAULT
                                                  : rd_data_i;
                    rd_req_o    <= 1'b0;
                    state       <= ST_DONE;
                end
            end
            ST_DONE: begin
                rd_req_o <= 1'b0;
                done_o   <= 1'b1;
            end
            default: begin
                state <= ST_SEC;
            end
        endcase
    end
end

endmodule
`default_nettype wire

/* hdl/fsp_range_check.v */
`include "fsp_consts.vh"
`default_nettype none
module fsp_range_check (
    // protection setting
    input  wire        open_i,
    input  wire [4:0]  size_i,
    // command under test
    input  wire [22:0] addr_i,
    input  wire [1:0]  op_i,
    // verdict
    output wire        reject_o
);

wire [22:0] base_addr = `FSP_DF_BASE;
wire [14:0] page      = addr_i[22:`FSP_DF_PAGE_LSB];
wire [14:0] base_page = base_addr[22:`FSP_DF_PAGE_LSB];
wire [14:0] last_page = base_page + {10'h000, size_i};
wire        in_range  = (page >= base_page) && (page <= last_page);
wire        is_alter  = (op_i == `FSP_OP_PROGRAM) ||
                        (op_i == `FSP_OP_SECT_ERASE);
wire        is_block  = (op_i == `FSP_OP_BLK_ERASE);

// ----------------------------------------
// any size protects at least one sector
// ----------------------------------------
assign reject_o = ~open_i & ((is_alter & in_range) |
                             is_block);

endmodule
`default_nettype wire

/* hdl/fsp_top.v */
// Our own choices: the Wishbone register port and the register offsets.
`include "fsp_consts.vh"
`default_nettype none
module fsp_top (
    // clock and reset
    input  wire        clock_i,
    input  wire        sys_rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // nonvolatile read port for reset load
    output wire        nv_rd_req_o,
    output wire [22:0] nv_rd_addr_o,
    input  wire        nv_rd_valid_i,
    input  wire [7:0]  nv_rd_data_i,
    input  wire        nv_rd_dbl_fault_i,
    // flash command request
    input  wire        cmd_valid_i,
    input  wire [1:0]  cmd_op_i,
    input  wire [22:0] cmd_addr_i,
    output wire        cmd_ready_o,
    output reg         cmd_launch_o,
    output reg         cmd_reject_o,
    // flash engine completion
    input  wire        engine_done_i,
    input  wire        key_match_i,
    // power modes
    input  wire        stop_req_i,
    output wire        stop_ack_o,
    // status to the chip
    output wire        secured_o,
    output wire        key_enabled_o,
    output wire        load_done_o,
    output wire        irq_o
);

// ----------------------------------------
// declarations
// ----------------------------------------
wire [7:0] load_sec;
wire [7:0] load_prot;
wire       load_done;
wire       range_reject;

reg  [7:0] flash_security_config;
reg  [7:0] dflash_protection_config;
reg        command_complete_flag;
reg        protection_violation_flag;
reg  [1:0] irq_status;
reg  [1:0] irq_mask;
reg        load_seen;
reg        cmd_is_verify;

wire       bus_req;
wire       bus_wr;
wire       bus_rd;
wire       hit_sec;
wire       hit_prot;
wire       hit_flash_status_reg;
wire       hit_istat;
wire       hit_imask;
wire       backdoor_key_enable;
wire [1:0] lock_state_field;
wire       dflash_protect_open;
wire [4:0] dflash_protect_size;
wire       cmd_take;
wire       cmd_bad;
wire       cc_event;
wire       viol_event;
wire       unlock_event;
wire       protection_violation_flag_w1c;
wire [1:0] istat_w1c;
reg  [31:0] next_rdata;

// ----------------------------------------
// reset-time loader
// ----------------------------------------
fsp_loader u_loader (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .rd_req_o       (nv_rd_req_o),
    .rd_addr_o      (nv_rd_addr_o),
    .rd_valid_i     (nv_rd_valid_i),
    .rd_data_i      (nv_rd_data_i),
    .rd_dbl_fault_i (nv_rd_dbl_fault_i),
    .sec_byte_o     (load_sec),
    .prot_byte_o    (load_prot),
    .done_o         (load_done)
);

assign load_done_o = load_done;

// ----------------------------------------
// field decode
// ----------------------------------------
assign lock_state_field =
    flash_security_config[`FSP_LOCK_HI:`FSP_LOCK_LO];

assign backdoor_key_enable =
    (flash_security_config[`FSP_KEYEN_HI:`FSP_KEYEN_LO]
     == `FSP_PAT_ON);

assign secured_o =
    (lock_state_field != `FSP_PAT_ON);

assign key_enabled_o = backdoor_key_enable;

assign dflash_protect_open =
    dflash_protection_config[`FSP_OPEN_BIT];

assign dflash_protect_size =
    dflash_protection_config[`FSP_SIZE_HI:0];

// ----------------------------------------
// protection range check
// ----------------------------------------
fsp_range_check u_range (
    .open_i   (dflash_protect_open),
    .size_i   (dflash_protect_size),
    .addr_i   (cmd_addr_i),
    .op_i     (cmd_op_i),
    .reject_o (range_reject)
);

// ----------------------------------------
// command acceptance
// ----------------------------------------
assign cmd_ready_o = load_done & command_complete_flag;

assign cmd_take = cmd_valid_i & cmd_ready_o;

assign cmd_bad =
    (cmd_op_i == `FSP_OP_VERIFY_KEY) ? ~backdoor_key_enable
                                     : range_reject;

always @(posedge clock_i) begin
    if (sys_rst_i) begin
        cmd_launch_o  <= 1'b0;
        cmd_reject_o  <= 1'b0;
        cmd_is_verify <= 1'b0;
    end else begin
        cmd_launch_o <= cmd_take & ~cmd_bad;
        cmd_reject_o <= cmd_take & cmd_bad;
        if (cmd_take & ~cmd_bad) begin
            cmd_is_verify <= (cmd_op_i == `FSP_OP_VERIFY_KEY);
        end
    end
end

// ----------------------------------------
// command complete flag
// ----------------------------------------
assign cc_event = ~command_complete_flag & engine_done_i;

always @(posedge clock_i) begin
    if (sys_rst_i) begin
        command_complete_flag <= 1'b0;
        load_seen             <= 1'b0;
    end else begin
        load_seen <= load_done;
        if (load_done & ~load_seen) begin
            command_complete_flag <= 1'b1;
        end else if (cmd_take & ~cmd_bad) begin
            command_complete_flag <= 1'b0;
        end else if (cc_event) begin
            command_complete_flag <= 1'b1;
        end
    end
end

// ----------------------------------------
// stop handshake
// ----------------------------------------
assign stop_ack_o =
    stop_req_i & load_done & command_complete_flag;

// ----------------------------------------
// wishbone decode
// ----------------------------------------
assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
assign bus_rd    = bus_req & ~wb_we_i;
assign hit_sec   = (wb_adr_i == `FSP_OFS_SEC);
assign hit_prot  = (wb_adr_i == `FSP_OFS_PROT);
assign hit_flash_status_reg = (wb_adr_i == `FSP_OFS_FLASH_STATUS_REG);
assign hit_istat = (wb_adr_i == `FSP_OFS_IRQ_STAT);
assign hit_imask = (wb_adr_i == `FSP_OFS_IRQ_MASK);

assign protection_violation_flag_w1c = bus_wr & hit_flash_status_reg & wb_dat_i[`FSP_VIOL_BIT];
assign istat_w1c  = (bus_wr & hit_istat) ? wb_dat_i[1:0] : 2'h0;

// ----------------------------------------
// security register
// ----------------------------------------
assign unlock_event = cmd_is_verify & cc_event & key_match_i;

always @(posedge clock_i) begin
    if (sys_rst_i) begin
        flash_security_config <= `FSP_SEC_RST;
    end else if (load_done & ~load_seen) begin
        flash_security_config <= load_sec;
    end else if (unlock_event & backdoor_key_enable) begin
        flash_security_config[`FSP_LOCK_HI:`FSP_LOCK_LO]
            <= `FSP_PAT_ON;
    end
end

// ----------------------------------------
// protection register
// ----------------------------------------
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        dflash_protection_config <= `FSP_PROT_RST;
    end else if (load_done & ~load_seen) begin
        dflash_protection_config <= load_prot;
    end else if (bus_wr & hit_prot & load_done) begin
        dflash_protection_config <= {wb_dat_i[7], 2'h0, wb_dat_i[4:0]};
    end
end

// ----------------------------------------
// violation flag, set wins over clear
// ----------------------------------------
assign viol_event = cmd_take & cmd_bad;

always @(posedge clock_i) begin
    if (sys_rst_i) begin
        protection_violation_flag <= 1'b0;
    end else if (viol_event) begin
        protection_violation_flag <= 1'b1;
    end else if (protection_violation_flag_w1c) begin
        protection_violation_flag <= 1'b0;
    end
end

// ----------------------------------------
// interrupt status and mask
// ----------------------------------------
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        irq_status <= 2'h0;
        irq_mask   <= 2'h0;
    end else begin
        irq_status[`FSP_IRQ_CC_BIT] <=
            cc_event | (irq_status[`FSP_IRQ_CC_BIT] &
                        ~istat_w1c[`FSP_IRQ_CC_BIT]);
        irq_status[`FSP_IRQ_VIOL_BIT] <=
            viol_event | (irq_status[`FSP_IRQ_VIOL_BIT] &
                          ~istat_w1c[`FSP_IRQ_VIOL_BIT]);
        if (bus_wr & hit_imask) begin
            irq_mask <= wb_dat_i[1:0];
        end
    end
end

assign irq_o = |(irq_status & irq_mask);

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
    next_rdata = 32'h00000000;
    if (hit_sec) begin
        next_rdata[7:0] = flash_security_config;
    end else if (hit_prot) begin
        next_rdata[7:0] = dflash_protection_config;
    end else if (hit_flash_status_reg) begin
        next_rdata[`FSP_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
        next_rdata[`FSP_VIOL_BIT] = protection_violation_flag;
    end else if (hit_istat) begin
        next_rdata[1:0] = irq_status;
    end else if (hit_imask) begin
        next_rdata[1:0] = irq_mask;
    end
end

// ----------------------------------------
// bus answer, one cycle after request
// ----------------------------------------
always @(posedge clock_i) begin
    if (sys_rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= bus_req;
        if (bus_rd) begin
            wb_dat_o <= next_rdata;
        end
    end
end

endmodule
`default_nettype wire

/* bench/fsp_nv_model.sv */
`default_nettype none
module fsp_nv_model (
    // clock
    input  wire logic        clock_i,
    // nonvolatile read port
    input  wire logic        req_i,
    input  wire logic [22:0] addr_i,
    output var  logic        valid_o,
    output var  logic [7:0]  data_o,
    output var  logic        fault_o,
    // stored bytes and fault flags
    input  wire logic [7:0]  sec_i,
    input  wire logic [7:0]  prot_i,
    input  wire logic [1:0]  flt_i,
    // flash engine
    input  wire logic        launch_i,
    output var  logic        done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       hit;
    logic [2:0] wait_cnt;
    logic [2:0] eng_cnt;
    initial {valid_o, data_o, fault_o, done_o, wait_cnt, eng_cnt} = 17'h0;
    assign hit = addr_i == 23'h7FFF0F;
    always @(posedge clock_i) begin
        valid_o  <= 1'b0;
        fault_o  <= 1'b0;
        data_o   <= ~data_o;
        wait_cnt <= (req_i === 1'b1 && !valid_o) ? wait_cnt + 3'h1 : 3'h0;
        if (wait_cnt == 3'h2) begin
            valid_o <= 1'b1;
            data_o  <= hit ? sec_i : prot_i;
            fault_o <= hit ? flt_i[0] : flt_i[1];
        end
        done_o  <= eng_cnt == 3'h1;
        eng_cnt <= (launch_i === 1'b1) ? 3'h5
                                       : eng_cnt - {2'h0, eng_cnt != 3'h0};
    end
endmodule
`default_nettype wire

/* bench/fsp_top_asserts.sv */
`default_nettype none
module fsp_top_asserts (
    // clock, reset, bus
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic        wb_ack_o,
    // reset load
    input  wire logic        nv_rd_req_o,
    input  wire logic [22:0] nv_rd_addr_o,
    input  wire logic        nv_rd_valid_i,
    input  wire logic        nv_rd_dbl_fault_i,
    // commands and status
    input  wire logic        cmd_valid_i,
    input  wire logic [1:0]  cmd_op_i,
    input  wire logic        cmd_ready_o,
    input  wire logic        cmd_launch_o,
    input  wire logic        cmd_reject_o,
    input  wire logic        engine_done_i,
    input  wire logic        key_match_i,
    input  wire logic        stop_req_i,
    input  wire logic        stop_ack_o,
    input  wire logic        secured_o,
    input  wire logic        key_enabled_o,
    input  wire logic        load_done_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic vrf;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i)
            vrf <= 1'b0;
        else if (cmd_valid_i && cmd_ready_o)
            vrf <= cmd_op_i == 2'h3;
    end
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack:
    assert property (p_ack) else $error("bus ack late");
    property p_ro;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00 && !wb_ack_o
        |=> $stable(secured_o) && $stable(key_enabled_o);
    endproperty
    a_ro:
    assert property (p_ro) else $error("security changed by write");
    property p_keyrej;
        cmd_valid_i && cmd_ready_o && cmd_op_i == 2'h3 && !key_enabled_o
        |=> cmd_reject_o;
    endproperty
    a_keyrej:
    assert property (p_keyrej) else $error("verify not refused");
    property p_answer;
        cmd_valid_i && cmd_ready_o |=> cmd_launch_o != cmd_reject_o;
    endproperty
    a_answer:
    assert property (p_answer) else $error("command without verdict");
    property p_unlock;
        vrf && engine_done_i && key_match_i && !cmd_ready_o && load_done_o
        |=> !secured_o;
    endproperty
    a_unlock:
    assert property (p_unlock) else $error("unlock not applied");
    property p_stop;
        stop_req_i && load_done_o && !cmd_ready_o |-> !stop_ack_o;
    endproperty
    a_stop:
    assert property (p_stop) else $error("stop granted while busy");
    property p_busy;
        cmd_launch_o |-> !cmd_ready_o && !stop_ack_o;
    endproperty
    a_busy:
    assert property (p_busy) else $error("stop granted after launch");
    property p_done;
        load_done_o && !cmd_ready_o && engine_done_i |=> cmd_ready_o;
    endproperty
    a_done:
    assert property (p_done) else $error("complete flag not set");
    property p_load;
        $fell(sys_rst_i) |=> nv_rd_req_o && nv_rd_addr_o == 23'h7FFF0F;
    endproperty
    a_load:
    assert property (p_load) else $error("security read not issued");
    property p_fault;
        nv_rd_req_o && nv_rd_valid_i && nv_rd_dbl_fault_i
        && nv_rd_addr_o == 23'h7FFF0F
        |-> ##[1:30] load_done_o && secured_o && !key_enabled_o;
    endproperty
    a_fault:
    assert property (p_fault) else $error("fault not secured");
endmodule
bind fsp_top fsp_top_asserts u_chk (.clock_i, .sys_rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .nv_rd_req_o, .nv_rd_addr_o,
    .nv_rd_valid_i, .nv_rd_dbl_fault_i, .cmd_valid_i, .cmd_op_i,
    .cmd_ready_o, .cmd_launch_o, .cmd_reject_o, .engine_done_i,
    .key_match_i, .stop_req_i, .stop_ack_o, .secured_o, .key_enabled_o,
    .load_done_o);
`default_nettype wire

/* bench/fsp_top_tb.sv */
`default_nettype none
module fsp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic cmd_valid = 1'b0, stop_req = 1'b0, key_match = 1'b0;
    logic [7:0] adr = 8'h00, sec = 8'hFF, prot = 8'h1F, nv_data;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
    logic [1:0] op = 2'h0, flt = 2'h0;
    logic [22:0] caddr = 23'h0, nv_addr;
    logic ack, nv_req, nv_valid, nv_fault, eng_done, launch, reject, ready;
    logic stop_ack, secured, key_en, load_done, irq;
    int miscompares = 0, checks = 0;
    initial forever #50 clock_i = ~clock_i;
    fsp_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
        .nv_rd_req_o(nv_req), .nv_rd_addr_o(nv_addr),
        .nv_rd_valid_i(nv_valid), .nv_rd_data_i(nv_data),
        .nv_rd_dbl_fault_i(nv_fault), .cmd_valid_i(cmd_valid),
        .cmd_op_i(op), .cmd_addr_i(caddr), .cmd_ready_o(ready),
        .cmd_launch_o(launch), .cmd_reject_o(reject),
        .engine_done_i(eng_done), .key_match_i(key_match),
        .stop_req_i(stop_req), .stop_ack_o(stop_ack), .secured_o(secured),
        .key_enabled_o(key_en), .load_done_o(load_done), .irq_o(irq));
    fsp_nv_model u_nv (.clock_i(clock_i), .req_i(nv_req), .addr_i(nv_addr),
        .valid_o(nv_valid), .data_o(nv_data), .fault_o(nv_fault),
        .sec_i(sec), .prot_i(prot), .flt_i(flt), .launch_i(launch),
        .done_o(eng_done));
    task automatic print_verdict;
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clock_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (ready !== 1'b1 && n < 100);
        if (n >= 100) begin
            miscompares++;
            print_verdict();
        end
    endtask
    task automatic boot(input logic [7:0] s, input logic [7:0] p,
                        input logic [1:0] f);
        @(posedge clock_i);
        sec <= s;
        prot <= p;
        flt <= f;
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        wait_ready();
    endtask
    task automatic cmd(input logic [1:0] o, input logic [22:0] a,
                       input logic rj);
        wait_ready();
        op <= o;
        caddr <= a;
        cmd_valid <= 1'b1;
        @(posedge clock_i);
        cmd_valid <= 1'b0;
        #1;
        chk(reject, rj);
        chk(launch, !rj);
    endtask
    // ----------------------------------------
    // security decode and read-only register
    // ----------------------------------------
    task automatic t_decode;
        logic [7:0] s;
        for (int i = 0; i < 4; i++) begin
            s = {i[1:0], 4'hF, i[1:0]};
            boot(s, 8'h80, 2'h0);
            sec <= 8'h82;
            repeat (20) @(posedge clock_i);
            chk(secured, i != 2);
            chk(key_en, i == 2);
            wb(1'b0, 8'h00, 32'h0);
            chk(rdat, {24'h0, s});
            wb(1'b1, 8'h00, {24'h0, ~s});
            wb(1'b0, 8'h00, 32'h0);
            chk(rdat, {24'h0, s});
            if (i != 2)
                cmd(2'h3, 23'h7FFF00, 1'b1);
        end
    endtask
    task automatic t_fault;
        boot(8'h82, 8'h80, 2'h1);
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'hFF);
        chk(key_en, 1'b0);
        boot(8'h82, 8'h80, 2'h2);
        wb(1'b0, 8'h04, 32'h0);
        chk(rdat, 32'h1F);
        chk(secured, 1'b0);
    endtask
    // ----------------------------------------
    // protected range, flags and interrupt; stop handshake and backdoor key unlock
    // ----------------------------------------
    task automatic t_prot;
        boot(8'hFF, 8'h01, 2'h0);
        wb(1'b1, 8'h10, 32'h3);
        cmd(2'h0, 23'h1001FF, 1'b1);
        wb(1'b0, 8'h08, 32'h0);
        chk(rdat, 32'h90);
        chk(irq, 1'b1);
        wb(1'b1, 8'h08, 32'h10);
        wb(1'b1, 8'h0C, 32'h3);
        chk(irq, 1'b0);
        cmd(2'h1, 23'h100200, 1'b0);
        wait_ready();
        #1;
        chk(irq, 1'b1);
        cmd(2'h2, 23'h100000, 1'b1);
        wb(1'b1, 8'h0C, 32'h3);
        wb(1'b1, 8'h10, 32'h0);
        wb(1'b1, 8'h04, 32'h80);
        cmd(2'h0, 23'h100000, 1'b0);
        cmd(2'h2, 23'h100000, 1'b0);
        wait_ready();
        wb(1'b0, 8'h14, 32'h0);
        chk(rdat, 32'h0);
        chk(irq, 1'b0);
    endtask
    task automatic t_unlock;
        boot(8'h80, 8'h1F, 2'h0);
        stop_req <= 1'b1;
        cmd(2'h0, 23'h000100, 1'b0);
        chk(stop_ack, 1'b0);
        wait_ready();
        #1;
        chk(stop_ack, 1'b1);
        @(posedge clock_i);
        key_match <= 1'b1;
        cmd(2'h3, 23'h7FFF00, 1'b0);
        wait_ready();
        key_match <= 1'b0;
        chk(secured, 1'b0);
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, 32'h82);
    endtask
    initial begin
        t_decode();
        t_fault();
        t_prot();
        t_unlock();
        print_verdict();
    end
endmodule
`default_nettype wire
